// ===== rtl/csl_pkg.sv
// constants, register map and carrier types for the channel sequencing limits block
// Contract
// - output voltage levels stored as unsigned 16-bit values
// - all such values share a fixed exponent
// - input voltage levels stored as 16-bit values
// - temperature thresholds stored as 16-bit values
// - four timer settings stored as millisecond values
// - turn-on wait counted on shared clock only
// - connect mode zero: wait ramp, then connect
// - other timers use shared clock, else oscillator
// - reach undervoltage level or raise timeout fault
// - zero timeout setting means no time limit
// - after turn-off request wait, then disable output
// - wait times clamp 13.1 s, fine steps below
// - wait times above 655 ms use coarse steps
// - ramp and timeout clamp 655 ms, fine steps
// - readback returns exactly the last written value for indices below 24
// - supervisor faults set status and pull alert
// - odd high-resolution current channels ignore output OV/UV faults and warnings, not the timeout
// - pin turn-off uses wait unless fast-off set
package csl_pkg;

	localparam int CSL_NUM_REGS = 24;
	localparam logic [4:0] CSL_IDX_OUT_TARGET = 5'h00;
	localparam logic [4:0] CSL_IDX_OUT_CEILING = 5'h01;
	localparam logic [4:0] CSL_IDX_OUT_MARGIN_HIGH = 5'h02;
	localparam logic [4:0] CSL_IDX_OUT_MARGIN_LOW = 5'h03;
	localparam logic [4:0] CSL_IDX_OUT_OV_FAULT = 5'h04;
	localparam logic [4:0] CSL_IDX_OUT_OV_WARN = 5'h05;
	localparam logic [4:0] CSL_IDX_OUT_UV_WARN = 5'h06;
	localparam logic [4:0] CSL_IDX_OUT_UV_FAULT = 5'h07;
	localparam logic [4:0] CSL_IDX_GOOD_ASSERT = 5'h08;
	localparam logic [4:0] CSL_IDX_GOOD_DEASSERT = 5'h09;
	localparam logic [4:0] CSL_IDX_IN_TURN_ON = 5'h0a;
	localparam logic [4:0] CSL_IDX_IN_TURN_OFF = 5'h0b;
	localparam logic [4:0] CSL_IDX_IN_OV_FAULT = 5'h0c;
	localparam logic [4:0] CSL_IDX_IN_OV_WARN = 5'h0d;
	localparam logic [4:0] CSL_IDX_IN_UV_WARN = 5'h0e;
	localparam logic [4:0] CSL_IDX_IN_UV_FAULT = 5'h0f;
	localparam logic [4:0] CSL_IDX_OT_FAULT = 5'h10;
	localparam logic [4:0] CSL_IDX_OT_WARN = 5'h11;
	localparam logic [4:0] CSL_IDX_UT_WARN = 5'h12;
	localparam logic [4:0] CSL_IDX_UT_FAULT = 5'h13;
	localparam logic [4:0] CSL_IDX_TURN_ON_WAIT = 5'h14;
	localparam logic [4:0] CSL_IDX_RAMP_SETTLE = 5'h15;
	localparam logic [4:0] CSL_IDX_RAMP_TIMEOUT = 5'h16;
	localparam logic [4:0] CSL_IDX_TURN_OFF_WAIT = 5'h17;
	localparam logic [4:0] CSL_IDX_OUT_MODE = 5'h18;
	localparam logic [15:0] CSL_REG_RESET = 16'h0000;

	localparam logic [2:0] CSL_OUT_MODE_TYPE = 3'h0;
	localparam logic [4:0] CSL_OUT_MODE_EXP = 5'h13;

	localparam int CSL_CLK_HZ = 200_000_000;
	localparam int CSL_FINE_STEP_US = 10;
	localparam int CSL_COARSE_STEP_US = 200;
	localparam int CSL_FINE_CYCLES = CSL_CLK_HZ / 1_000_000 * CSL_FINE_STEP_US;
	localparam int CSL_COARSE_PER_FINE = CSL_COARSE_STEP_US / CSL_FINE_STEP_US;
	localparam logic [6:0] CSL_FINE_PER_MS = 7'(1000 / CSL_FINE_STEP_US);
	localparam logic [6:0] CSL_COARSE_PER_MS = 7'(1000 / CSL_COARSE_STEP_US);
	localparam int CSL_FINE_LIMIT_MS = 655;
	localparam int CSL_COARSE_LIMIT_MS = 13100;
	localparam logic [15:0] CSL_FINE_MAX = 16'(CSL_FINE_LIMIT_MS * 1000 / CSL_FINE_STEP_US);
	localparam logic [15:0] CSL_COARSE_MAX =
		16'(CSL_COARSE_LIMIT_MS * 1000 / CSL_COARSE_STEP_US);

	localparam int CSL_SV_OV_FAULT_BIT = 7;
	localparam int CSL_SV_OV_WARN_BIT = 6;
	localparam int CSL_SV_UV_WARN_BIT = 5;
	localparam int CSL_SV_UV_FAULT_BIT = 4;
	localparam int CSL_SV_RAMP_TIMEOUT_BIT = 2;
	localparam int CSL_SB_OV_BIT = 5;
	localparam int CSL_SB_UV_BIT = 3;
	localparam int CSL_SW_VOUT_BIT = 15;

	typedef struct packed {
		logic controlled_on;
		logic use_cmd;
		logic use_pin;
		logic fast_off;
		logic [1:0] dac_mode;
		logic odd_channel;
		logic hires_current;
	} csl_cfg_s;

	typedef struct packed {
		logic unit_coarse;
		logic [15:0] count;
	} csl_timer_s;

	typedef enum logic [2:0] {
		CSL_OFF,
		CSL_ON_WAIT,
		CSL_RAMP,
		CSL_RUN,
		CSL_OFF_WAIT
	} csl_state_e;

endpackage

// ===== rtl/csl_channel_limits.sv
// one supply channel: limit storage, timer conversion, sequencing and supervision
`timescale 1ns/10ps
`default_nettype none
module csl_channel_limits
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [4:0] reg_index,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	output logic reg_rd_valid,
	input wire csl_pkg::csl_cfg_s cfg,
	input wire logic op_on,
	input wire logic channel_control_pin,
	input wire logic share_clk_in,
	input wire logic share_clk_present,
	input wire logic [15:0] vout_meas,
	input wire logic vout_meas_valid,
	input wire logic clear_faults,
	output logic vout_enable,
	output logic dac_connect,
	output logic [7:0] status_vout,
	output logic [7:0] status_byte,
	output logic [15:0] status_word,
	output logic host_alert_n,
	output logic host_alert_oe
);
	import csl_pkg::*;

	logic [15:0] regs [CSL_NUM_REGS];
	csl_timer_s on_wait_t, off_wait_t, ramp_t, timeout_t;
	logic [1:0] pin_sync, share_sync;
	logic [11:0] osc_div;
	logic [4:0] share_sub, osc_sub;
	csl_state_e state, next_state;
	logic [15:0] seq_cnt, tmo_cnt;
	logic timeout_disabled, share_last, share_fine, osc_fine, share_coarse, osc_coarse;
	logic tmo_running, uv_unmasked, run_request, pin_off, seq_tick, seq_done;
	logic ramp_fine, ramp_expired, mask_out;
	logic ev_ov_fault, ev_ov_warn, ev_uv_warn, ev_uv_fault, ev_tmo;

	// linear value in ms times steps per ms, rounded to nearest; negative reads as zero
	function automatic logic [39:0] l11_steps(input logic [15:0] v, input logic [6:0] mult);
		logic signed [10:0] mant;
		logic signed [4:0] expo;
		logic [39:0] prod;
		logic [4:0] sh;
		mant = v[10:0];
		expo = v[15:11];
		prod = 40'(mant[9:0]) * 40'(mult);
		sh = 5'(-expo);
		if (mant[10])
			l11_steps = 40'h0;
		else if (!expo[4])
			l11_steps = prod << expo[3:0];
		else
			l11_steps = (prod + (40'h1 << (sh - 5'h1))) >> sh;
	endfunction

	function automatic logic [15:0] clamp16(input logic [39:0] x, input logic [15:0] lim);
		clamp16 = (x > 40'(lim)) ? lim : x[15:0];
	endfunction

	// wait timers switch to coarse steps once the fine count passes its range
	function automatic csl_timer_s wait_timer(input logic [15:0] v);
		logic [39:0] fine;
		fine = l11_steps(v, CSL_FINE_PER_MS);
		if (fine > 40'(CSL_FINE_MAX))
		begin
			wait_timer.unit_coarse = 1'b1;
			wait_timer.count = clamp16(l11_steps(v, CSL_COARSE_PER_MS), CSL_COARSE_MAX);
		end
		else
		begin
			wait_timer.unit_coarse = 1'b0;
			wait_timer.count = fine[15:0];
		end
	endfunction

	function automatic csl_timer_s ramp_timer(input logic [15:0] v);
		ramp_timer.unit_coarse = 1'b0;
		ramp_timer.count = clamp16(l11_steps(v, CSL_FINE_PER_MS), CSL_FINE_MAX);
	endfunction

	// raw storage, all formats kept bit for bit
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < CSL_NUM_REGS; i++)
				regs[i] <= CSL_REG_RESET;
		end
		else if (reg_wr_en && (int'(reg_index) < CSL_NUM_REGS))
		begin
			regs[reg_index] <= reg_wdata;
		end
	end

	// conversion happens once, on write, so the counters only compare
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			on_wait_t <= '0;
			off_wait_t <= '0;
			ramp_t <= '0;
			timeout_t <= '0;
			timeout_disabled <= 1'b1;
		end
		else if (reg_wr_en)
		begin
			case (reg_index)
				CSL_IDX_TURN_ON_WAIT: on_wait_t <= wait_timer(reg_wdata);
				CSL_IDX_TURN_OFF_WAIT: off_wait_t <= wait_timer(reg_wdata);
				CSL_IDX_RAMP_SETTLE: ramp_t <= ramp_timer(reg_wdata);
				CSL_IDX_RAMP_TIMEOUT:
				begin
					timeout_t <= ramp_timer(reg_wdata);
					timeout_disabled <= (reg_wdata[10:0] == 11'h000);
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			reg_rdata <= 16'h0000;
			reg_rd_valid <= 1'b0;
		end
		else
		begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en)
			begin
				if (reg_index == CSL_IDX_OUT_MODE)
					reg_rdata <= {8'h00, CSL_OUT_MODE_TYPE, CSL_OUT_MODE_EXP};
				else if (int'(reg_index) < CSL_NUM_REGS)
					reg_rdata <= regs[reg_index];
				else
					reg_rdata <= 16'h0000;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_sync <= 2'b00;
			share_sync <= 2'b00;
			share_last <= 1'b0;
		end
		else
		begin
			pin_sync <= {pin_sync[0], channel_control_pin};
			share_sync <= {share_sync[0], share_clk_in};
			share_last <= share_sync[1];
		end
	end

	// each rising shared clock edge is one fine step
	assign share_fine = share_sync[1] && !share_last;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			osc_div <= 12'h000;
			osc_fine <= 1'b0;
		end
		else
		begin
			osc_fine <= (osc_div == 12'(CSL_FINE_CYCLES - 1));
			if (osc_div == 12'(CSL_FINE_CYCLES - 1))
				osc_div <= 12'h000;
			else
				osc_div <= osc_div + 12'h001;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			share_sub <= 5'h00;
			osc_sub <= 5'h00;
		end
		else
		begin
			if (share_fine)
				share_sub <= (share_sub == 5'(CSL_COARSE_PER_FINE - 1)) ? 5'h00 : share_sub + 5'h01;
			if (osc_fine)
				osc_sub <= (osc_sub == 5'(CSL_COARSE_PER_FINE - 1)) ? 5'h00 : osc_sub + 5'h01;
		end
	end

	assign share_coarse = share_fine && (share_sub == 5'(CSL_COARSE_PER_FINE - 1));
	assign osc_coarse = osc_fine && (osc_sub == 5'(CSL_COARSE_PER_FINE - 1));
	assign ramp_fine = share_clk_present ? share_fine : osc_fine;

	assign pin_off = cfg.use_pin && !pin_sync[1];
	assign run_request = !cfg.controlled_on || ((cfg.use_pin || cfg.use_cmd) &&
		(!cfg.use_pin || pin_sync[1]) && (!cfg.use_cmd || op_on));

	always_comb
	begin
		seq_tick = 1'b0;
		seq_done = 1'b0;
		case (state)
			CSL_ON_WAIT:
			begin
				seq_tick = on_wait_t.unit_coarse ? share_coarse : share_fine;
				seq_done = (seq_cnt >= on_wait_t.count);
			end
			CSL_RAMP:
			begin
				seq_tick = ramp_fine;
				seq_done = (seq_cnt >= ramp_t.count);
			end
			CSL_OFF_WAIT:
			begin
				seq_tick = off_wait_t.unit_coarse ? (share_clk_present ? share_coarse : osc_coarse) :
					ramp_fine;
				seq_done = (seq_cnt >= off_wait_t.count);
			end
			default: ;
		endcase
	end

	always_comb
	begin
		next_state = state;
		case (state)
			CSL_OFF:
				if (run_request)
					next_state = CSL_ON_WAIT;
			CSL_ON_WAIT:
				if (!run_request)
					next_state = CSL_OFF;
				else if (seq_done)
					next_state = CSL_RAMP;
			CSL_RAMP, CSL_RUN:
				if (!run_request)
					next_state = (pin_off && cfg.fast_off) ? CSL_OFF : CSL_OFF_WAIT;
				else if (state == CSL_RAMP && seq_done)
					next_state = CSL_RUN;
			CSL_OFF_WAIT:
				if (seq_done)
					next_state = CSL_OFF;
				else if (run_request)
					next_state = CSL_RUN;
			default: next_state = CSL_OFF;
		endcase
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= CSL_OFF;
			seq_cnt <= 16'h0000;
		end
		else
		begin
			state <= next_state;
			if (next_state != state)
				seq_cnt <= 16'h0000;
			else if (seq_tick && !seq_done)
				seq_cnt <= seq_cnt + 16'h0001;
		end
	end

	// enable drops together with the state so fast-off costs one cycle only
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			vout_enable <= 1'b0;
			dac_connect <= 1'b0;
		end
		else
		begin
			vout_enable <= (next_state == CSL_RAMP) || (next_state == CSL_RUN) ||
				(next_state == CSL_OFF_WAIT);
			dac_connect <= (next_state == CSL_RUN) && (cfg.dac_mode == 2'b00);
		end
	end

	assign ramp_expired = tmo_running && !timeout_disabled && (tmo_cnt >= timeout_t.count);
	assign mask_out = cfg.odd_channel && cfg.hires_current;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tmo_cnt <= 16'h0000;
			tmo_running <= 1'b0;
			uv_unmasked <= 1'b0;
		end
		else if (!vout_enable)
		begin
			tmo_cnt <= 16'h0000;
			tmo_running <= 1'b0;
			uv_unmasked <= 1'b0;
		end
		else
		begin
			if (!uv_unmasked && !tmo_running && tmo_cnt == 16'h0000)
				tmo_running <= 1'b1;
			if (vout_meas_valid && vout_meas > regs[CSL_IDX_OUT_UV_FAULT])
			begin
				uv_unmasked <= 1'b1;
				tmo_running <= 1'b0;
			end
			else if (ramp_expired)
			begin
				// parked so the timer cannot rearm before the next enable
				tmo_running <= 1'b0;
				tmo_cnt <= 16'hffff;
			end
			if (tmo_running && ramp_fine && !ramp_expired)
				tmo_cnt <= tmo_cnt + 16'h0001;
		end
	end

	assign ev_tmo = ramp_expired && !uv_unmasked && !(vout_meas_valid &&
		vout_meas > regs[CSL_IDX_OUT_UV_FAULT]);
	assign ev_ov_fault = vout_meas_valid && !mask_out &&
		vout_meas > regs[CSL_IDX_OUT_OV_FAULT];
	assign ev_ov_warn = vout_meas_valid && !mask_out &&
		vout_meas > regs[CSL_IDX_OUT_OV_WARN];
	assign ev_uv_warn = vout_meas_valid && !mask_out && uv_unmasked &&
		vout_meas < regs[CSL_IDX_OUT_UV_WARN];
	assign ev_uv_fault = vout_meas_valid && !mask_out && uv_unmasked &&
		vout_meas < regs[CSL_IDX_OUT_UV_FAULT];

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			status_vout <= 8'h00;
		else
		begin
			status_vout[CSL_SV_OV_FAULT_BIT] <= ev_ov_fault ||
				(status_vout[CSL_SV_OV_FAULT_BIT] && !clear_faults);
			status_vout[CSL_SV_OV_WARN_BIT] <= ev_ov_warn ||
				(status_vout[CSL_SV_OV_WARN_BIT] && !clear_faults);
			status_vout[CSL_SV_UV_WARN_BIT] <= ev_uv_warn ||
				(status_vout[CSL_SV_UV_WARN_BIT] && !clear_faults);
			status_vout[CSL_SV_UV_FAULT_BIT] <= ev_uv_fault ||
				(status_vout[CSL_SV_UV_FAULT_BIT] && !clear_faults);
			status_vout[CSL_SV_RAMP_TIMEOUT_BIT] <= ev_tmo ||
				(status_vout[CSL_SV_RAMP_TIMEOUT_BIT] && !clear_faults);
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			status_byte <= 8'h00;
			status_word <= 16'h0000;
			host_alert_n <= 1'b1;
			host_alert_oe <= 1'b0;
		end
		else
		begin
			status_byte <= 8'h00;
			status_byte[CSL_SB_OV_BIT] <= ev_ov_fault ||
				(status_byte[CSL_SB_OV_BIT] && !clear_faults);
			status_byte[CSL_SB_UV_BIT] <= ev_uv_fault ||
				(status_byte[CSL_SB_UV_BIT] && !clear_faults);
			status_word[7:0] <= 8'h00;
			status_word[CSL_SB_OV_BIT] <= ev_ov_fault ||
				(status_word[CSL_SB_OV_BIT] && !clear_faults);
			status_word[CSL_SB_UV_BIT] <= ev_uv_fault ||
				(status_word[CSL_SB_UV_BIT] && !clear_faults);
			status_word[14:8] <= 7'h00;
			status_word[CSL_SW_VOUT_BIT] <= (ev_ov_fault || ev_ov_warn || ev_uv_warn ||
				ev_uv_fault || ev_tmo) || (status_word[CSL_SW_VOUT_BIT] && !clear_faults);
			// open drain: the pad only ever pulls low
			host_alert_n <= 1'b0;
			host_alert_oe <= ev_ov_fault || ev_uv_fault || ev_ov_warn || ev_uv_warn || ev_tmo ||
				(host_alert_oe && !clear_faults);
		end
	end

endmodule
`default_nettype wire

// ===== verif/csl_channel_limits_sva.sv
// assertion checker for the channel sequencing limits block
`timescale 1ns/10ps
`default_nettype none
module csl_channel_limits_chk
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic reg_rd_en,
	input wire logic [4:0] reg_index,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire csl_pkg::csl_cfg_s cfg,
	input wire logic channel_control_pin,
	input wire logic clear_faults,
	input wire logic vout_enable,
	input wire logic dac_connect,
	input wire logic [7:0] status_vout,
	input wire logic [7:0] status_byte,
	input wire logic [15:0] status_word,
	input wire logic host_alert_n,
	input wire logic host_alert_oe
);
	import csl_pkg::*;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	a_read_answer_lag: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read strobe got no answer");
	a_no_stray_answer: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("read answer without strobe");
	a_mode_fixed_exp: assert property (reg_rd_en && reg_index == CSL_IDX_OUT_MODE
		|=> reg_rdata == {8'h00, CSL_OUT_MODE_TYPE, CSL_OUT_MODE_EXP})
		else $error("mode readback wrong");
	a_dac_after_enable: assert property (dac_connect
		|-> vout_enable && $past(cfg.dac_mode) == 2'h0)
		else $error("dac connected out of place");
	a_fast_off_drop: assert property ($fell(channel_control_pin) && cfg.use_pin && cfg.fast_off
		|-> ##[1:5] !vout_enable)
		else $error("fast off too slow");
	a_ov_sets_all: assert property ($rose(status_vout[CSL_SV_OV_FAULT_BIT])
		|-> status_byte[CSL_SB_OV_BIT] && status_word[CSL_SW_VOUT_BIT] && host_alert_oe)
		else $error("ov fault status incomplete");
	a_timeout_alerts: assert property ($rose(status_vout[CSL_SV_RAMP_TIMEOUT_BIT]) |-> host_alert_oe)
		else $error("timeout without alert");
	a_hires_masked: assert property (cfg.odd_channel && cfg.hires_current
		|=> !$rose(status_vout[CSL_SV_OV_FAULT_BIT]) && !$rose(status_vout[CSL_SV_UV_FAULT_BIT]))
		else $error("masked channel raised fault");
	a_alert_sticky: assert property ($fell(host_alert_oe) |-> $past(clear_faults))
		else $error("alert released without clear");
	a_alert_pulls_low: assert property (host_alert_oe |-> !host_alert_n)
		else $error("alert driven high");
	a_ov_held: assert property (status_vout[CSL_SV_OV_FAULT_BIT] && !clear_faults
		|=> status_vout[CSL_SV_OV_FAULT_BIT])
		else $error("ov status lost");
	c_enable: cover property ($rose(vout_enable));
	c_dac: cover property ($rose(dac_connect));
	c_timeout: cover property ($rose(status_vout[CSL_SV_RAMP_TIMEOUT_BIT]));
endmodule
bind csl_channel_limits csl_channel_limits_chk u_chk (.clk, .rst_n, .reg_rd_en, .reg_index,
	.reg_rdata, .reg_rd_valid, .cfg, .channel_control_pin, .clear_faults, .vout_enable,
	.dac_connect, .status_vout, .status_byte, .status_word, .host_alert_n, .host_alert_oe);
`default_nettype wire

// ===== verif/csl_conv_model.sv
// converter model on the far side of the enable output
`timescale 1ns/10ps
`default_nettype none
module csl_conv_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic [15:0] level,
	output logic [15:0] vout_meas,
	output logic vout_meas_valid
);
	logic [3:0] settle;
	// output settles 16 cycles after enable, collapses at once when off
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			settle <= 4'h0;
			vout_meas <= 16'h0000;
		end
		else if (!enable)
		begin
			settle <= 4'h0;
			vout_meas <= 16'h0000;
		end
		else if (settle != 4'hf)
			settle <= settle + 4'h1;
		else
			vout_meas <= level;
	end
	assign vout_meas_valid = rst_n;
endmodule
`default_nettype wire

// ===== verif/test_channel_sequencing_limits.sv
// self-checking bench for the channel sequencing limits block
`timescale 1ns/10ps
`default_nettype none
module test_channel_sequencing_limits;
	import csl_pkg::*;
	typedef struct packed {logic [4:0] idx; logic [15:0] wdata; logic [15:0] rdata;} csl_row_s;
	logic clk, rst_n, reg_wr_en, reg_rd_en, reg_rd_valid, op_on, channel_control_pin;
	logic share_clk_in, share_present, share_run, clear_faults, vout_meas_valid;
	logic vout_enable, dac_connect, host_alert_n, host_alert_oe, alert_line;
	logic [4:0] reg_index;
	logic [15:0] reg_wdata, reg_rdata, vout_meas, level, status_word;
	logic [7:0] status_vout, status_byte;
	csl_cfg_s cfg;
	int error_cnt, samples_checked, edges, cyc, n;
	csl_row_s rows [9] = '{'{5'h00, 16'h1234, 16'h1234}, '{5'h04, 16'hffff, 16'hffff},
		'{5'h05, 16'hffff, 16'hffff}, '{5'h07, 16'h1000, 16'h1000}, '{5'h0a, 16'hca40, 16'hca40},
		'{5'h13, 16'he580, 16'he580}, '{5'h17, 16'h7bff, 16'h7bff}, '{5'h18, 16'hffff, 16'h0013},
		'{5'h19, 16'h5555, 16'h0000}};
	assign alert_line = host_alert_oe ? host_alert_n : 1'b1;
	csl_channel_limits dut (.clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_index(reg_index), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .cfg(cfg), .op_on(op_on),
		.channel_control_pin(channel_control_pin), .share_clk_in(share_clk_in),
		.share_clk_present(share_present), .vout_meas(vout_meas),
		.vout_meas_valid(vout_meas_valid), .clear_faults(clear_faults),
		.vout_enable(vout_enable), .dac_connect(dac_connect), .status_vout(status_vout),
		.status_byte(status_byte), .status_word(status_word), .host_alert_n(host_alert_n),
		.host_alert_oe(host_alert_oe));
	csl_conv_model conv (.clk(clk), .rst_n(rst_n), .enable(vout_enable), .level(level),
		.vout_meas(vout_meas), .vout_meas_valid(vout_meas_valid));
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// shared timebase stands low while stopped; one rising edge per 100 ns
	initial
	begin
		share_clk_in = 1'b0;
		forever #50 share_clk_in = share_run ? ~share_clk_in : 1'b0;
	end
	always @(posedge share_clk_in)
		edges++;
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			error_cnt++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (error_cnt == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [4:0] idx, input logic [15:0] d);
		reg_index = idx;
		reg_wdata = d;
		reg_wr_en = 1'b1;
		@(negedge clk);
		reg_wr_en = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd_chk(input logic [4:0] idx, input logic [15:0] exp);
		reg_index = idx;
		reg_rd_en = 1'b1;
		@(negedge clk);
		reg_rd_en = 1'b0;
		chk({15'h0, reg_rd_valid}, 16'h0001);
		chk(reg_rdata, exp);
	endtask
	function automatic logic pick(input int sel);
		case (sel)
			0: return vout_enable;
			1: return dac_connect;
			default: return ~vout_enable;
		endcase
	endfunction
	// bounded wait; n tells how many cycles it took
	task automatic wait_on(input int sel, input int lim);
		n = 0;
		while (pick(sel) !== 1'b1 && n < lim)
		begin
			@(negedge clk);
			n++;
		end
		chk({15'h0, pick(sel)}, 16'h0001);
	endtask
	task automatic pulse_clear();
		clear_faults = 1'b1;
		@(negedge clk);
		clear_faults = 1'b0;
		@(negedge clk);
	endtask
	initial
	begin
		{rst_n, reg_wr_en, reg_rd_en, reg_index, reg_wdata} = '0;
		{op_on, channel_control_pin, share_run, clear_faults} = '0;
		share_present = 1'b1;
		cfg = 8'hc0;
		level = 16'h2000;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		chk({13'h0, alert_line, host_alert_oe, vout_enable}, 16'h0004);
		rd_chk(CSL_IDX_TURN_ON_WAIT, CSL_REG_RESET);
		foreach (rows[i])
		begin
			wr(rows[i].idx, rows[i].wdata);
			rd_chk(rows[i].idx, rows[i].rdata);
		end
		// 28/1024 ms is 2.73 fine steps, so nearest gives 3 and truncation 2
		wr(CSL_IDX_TURN_ON_WAIT, 16'hb01c);
		wr(CSL_IDX_RAMP_SETTLE, 16'hb01f);
		wr(CSL_IDX_RAMP_TIMEOUT, 16'hb01f);
		wr(CSL_IDX_TURN_OFF_WAIT, 16'hb01f);
		op_on = 1'b1;
		repeat (50) @(negedge clk);
		chk({15'h0, vout_enable}, 16'h0000);
		edges = 0;
		share_run = 1'b1;
		wait_on(0, 400);
		chk(edges[15:0], 16'h0003);
		wait_on(1, 400);
		chk(edges[15:0], 16'h0006);
		repeat (200) @(negedge clk);
		chk({8'h00, status_vout}, 16'h0000);
		share_run = 1'b0;
		op_on = 1'b0;
		repeat (50) @(negedge clk);
		chk({15'h0, vout_enable}, 16'h0001);
		edges = 0;
		share_run = 1'b1;
		wait_on(2, 400);
		chk(edges[15:0], 16'h0003);
		share_run = 1'b0;
		share_present = 1'b0;
		level = 16'h0800;
		wr(CSL_IDX_TURN_ON_WAIT, 16'h0000);
		op_on = 1'b1;
		wait_on(0, 20);
		wait_on(1, 8000);
		chk({15'h0, n >= 4000 && n <= 6010}, 16'h0001);
		repeat (2100) @(negedge clk);
		chk({8'h00, status_vout}, 16'h0004);
		chk({15'h0, alert_line}, 16'h0000);
		pulse_clear();
		chk({status_vout, 7'h0, host_alert_oe}, 16'h0000);
		share_present = 1'b1;
		share_run = 1'b1;
		op_on = 1'b0;
		wait_on(2, 400);
		wr(CSL_IDX_RAMP_TIMEOUT, 16'h0000);
		op_on = 1'b1;
		wait_on(0, 20);
		repeat (300) @(negedge clk);
		chk({8'h00, status_vout}, 16'h0000);
		level = 16'h4000;
		wr(CSL_IDX_OUT_OV_FAULT, 16'h3000);
		repeat (30) @(negedge clk);
		chk({10'h0, status_vout[CSL_SV_OV_FAULT_BIT], status_byte[CSL_SB_OV_BIT],
			status_word[CSL_SB_OV_BIT], status_word[CSL_SW_VOUT_BIT], alert_line,
			host_alert_oe}, 16'h003d);
		cfg = 8'hc3;
		pulse_clear();
		repeat (20) @(negedge clk);
		chk({8'h00, status_vout}, 16'h0000);
		cfg = 8'hc0;
		repeat (10) @(negedge clk);
		chk({15'h0, status_vout[CSL_SV_OV_FAULT_BIT]}, 16'h0001);
		cfg = 8'hc4;
		repeat (2) @(negedge clk);
		chk({14'h0, vout_enable, dac_connect}, 16'h0002);
		channel_control_pin = 1'b1;
		cfg = 8'hb0;
		repeat (10) @(negedge clk);
		chk({15'h0, vout_enable}, 16'h0001);
		// timebase stopped, so only fast-off can drop the enable
		share_run = 1'b0;
		channel_control_pin = 1'b0;
		repeat (6) @(negedge clk);
		chk({15'h0, vout_enable}, 16'h0000);
		rst_n = 1'b0;
		@(negedge clk);
		chk({15'h0, vout_enable}, 16'h0000);
		rst_n = 1'b1;
		@(negedge clk);
		rd_chk(CSL_IDX_OUT_TARGET, CSL_REG_RESET);
		finish_test();
	end
endmodule
`default_nettype wire
